// File: hw/line_sense_defines.vh
// address map, field positions and reset values of the line sense register bank
`ifndef LINE_SENSE_DEFINES_VH
`define LINE_SENSE_DEFINES_VH

`define LOOP_VOLTAGE_SENSE_ADDR       8'h4E
`define LOOP_CURRENT_SENSE_ADDR       8'h4F
`define TIP_VOLTAGE_SENSE_ADDR        8'h50
`define RING_VOLTAGE_SENSE_ADDR       8'h51
`define BATTERY_VOLTAGE_SENSE_A_ADDR  8'h52
`define BATTERY_VOLTAGE_SENSE_B_ADDR  8'h53
`define DRIVER_ONE_CURRENT_SENSE_ADDR 8'h54
`define DRIVER_TWO_CURRENT_SENSE_ADDR 8'h55
`define DRIVER_THREE_CURRENT_SENSE_ADDR 8'h56
`define DRIVER_FOUR_CURRENT_SENSE_ADDR  8'h57
`define EXTRA_BIAS_CTRL_ADDR          8'h58

`define SENSE_BASE_ADDR               8'h4E
`define SENSE_COUNT                   10

`define SENSE_IDX_LOOP_VOLTAGE        4'h0
`define SENSE_IDX_LOOP_CURRENT        4'h1
`define SENSE_IDX_TIP                 4'h2
`define SENSE_IDX_RING                4'h3
`define SENSE_IDX_BATT_A              4'h4
`define SENSE_IDX_BATT_B              4'h5
`define SENSE_IDX_DRV_ONE             4'h6
`define SENSE_IDX_DRV_TWO             4'h7
`define SENSE_IDX_DRV_THREE           4'h8
`define SENSE_IDX_DRV_FOUR            4'h9

// bit i set: sense register i is cleared by a host read
`define SENSE_READ_CLEAR_MASK         10'h248

`define LOOP_POLARITY_BIT             6
`define LOOP_MAGNITUDE_W              6
`define SENSE_RESET_VALUE             8'h00
`define EXTRA_BIAS_ENABLE_BIT         0
`define EXTRA_BIAS_CTRL_RESET         1'b0

`endif

// File: hw/sign_magnitude_split.v
// signed converter sample to polarity flag plus saturated magnitude
`timescale 1ns/1ps
module sign_magnitude_split #(
    parameter IN_W  = 9,
    parameter MAG_W = 6
) (
    input  wire [IN_W-1:0]  sample,     // two's complement, one step per lsb
    output wire             polarity,   // 1 when sample is negative
    output wire [MAG_W-1:0] magnitude   // absolute value, clipped at full scale
);
    localparam [IN_W-1:0] FULL_SCALE = {{(IN_W-MAG_W){1'b0}}, {MAG_W{1'b1}}};

    wire [IN_W-1:0] absolute;

    assign polarity  = sample[IN_W-1];
    // most negative input wraps to itself, still correct read as unsigned
    assign absolute  = polarity ? (~sample + {{(IN_W-1){1'b0}}, 1'b1}) : sample;
    assign magnitude = (absolute > FULL_SCALE) ? FULL_SCALE[MAG_W-1:0] : absolute[MAG_W-1:0];
endmodule

// File: hw/bias_trim.v
// removes the extra bias share from a driver current code when enabled
`timescale 1ns/1ps
module bias_trim #(
    parameter W = 8
) (
    input  wire [W-1:0] current_code,  // raw transistor current
    input  wire [W-1:0] bias_code,     // extra bias current at the same scale
    input  wire         enable,        // extra bias active
    output wire [W-1:0] trimmed        // reported current
);
    // floor at zero so a noisy bias estimate never wraps to full scale
    assign trimmed = !enable ? current_code :
                     (current_code > bias_code) ? (current_code - bias_code) : {W{1'b0}};
endmodule

// File: hw/line_sense_readout_bank.v
// line measurement register bank behind the host register port, read-only except the writable extra bias control at 8'h58
// Notes on behaviour
// (R1) loop voltage bit 6: 1 when ring exceeds tip
// (R2) loop voltage bits 5:0: magnitude, 1.5 V steps
// (R3) loop current bit 6: 1 for reverse current
// (R4) loop current bits 5:0: magnitude, 1.25 mA steps
// (R5) tip voltage: 8-bit code, 0 V to -95.88 V
// (R6) ring voltage: 8-bit code, .376 V steps
// (R7) two battery registers, identical .376 V scaling
// (R8) drivers one, two: 8-bit, .319 mA steps
// (R9) extra bias enabled: drivers one, two exclude it
// (R10) drivers three, four: 8-bit, 37.6 uA steps
// (R11) host writes to sense registers ignored; loop bit 7 reads zero
// (R12) registers follow each new converter sample
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`include "line_sense_defines.vh"
module line_sense_readout_bank #(
    parameter LOOP_W = 9,
    parameter DRV_W  = 8
) (
    input  wire              ref_clk,                 // 200 MHz clock
    input  wire              srst,                    // synchronous reset, high
    input  wire [7:0]        addr,                    // register address
    input  wire [7:0]        wr_data,                 // write data
    input  wire              wr_strobe,               // one-cycle write
    input  wire              rd_strobe,               // one-cycle read
    output reg  [7:0]        rd_data,                 // read data, cycle after strobe
    input  wire              loop_valid,              // new loop samples
    input  wire [LOOP_W-1:0] loop_volt_sample,        // signed tip minus ring, 1.5 V lsb
    input  wire [LOOP_W-1:0] loop_current_sample,     // signed loop current, 1.25 mA lsb
    input  wire              line_valid,              // new tip, ring, battery codes
    input  wire [7:0]        tip_voltage_code,        // tip to ground code
    input  wire [7:0]        ring_voltage_code,       // ring to ground code
    input  wire [7:0]        battery_voltage_code_a,  // battery sense one code
    input  wire [7:0]        battery_voltage_code_b,  // battery sense two code
    input  wire              driver_valid,            // new driver current codes
    input  wire [DRV_W-1:0]  driver_one_current,      // raw, .319 mA lsb
    input  wire [DRV_W-1:0]  driver_two_current,      // raw, .319 mA lsb
    input  wire [DRV_W-1:0]  driver_three_current,    // 37.6 uA lsb
    input  wire [DRV_W-1:0]  driver_four_current,     // 37.6 uA lsb
    input  wire [DRV_W-1:0]  extra_bias_current_one,  // bias share in driver one
    input  wire [DRV_W-1:0]  extra_bias_current_two,  // bias share in driver two
    output wire              extra_bias_enable        // control bit, from register
);
    // read-clear registers by index, so the loop can test one bit per register
    localparam [`SENSE_COUNT-1:0] CLEAR_MASK = `SENSE_READ_CLEAR_MASK;

    reg                     bias_enable;
    reg  [7:0]              sense [0:`SENSE_COUNT-1];
    wire                    volt_polarity;
    wire [5:0]              volt_magnitude;
    wire                    cur_polarity;
    wire [5:0]              cur_magnitude;
    wire [2*DRV_W-1:0]      raw_pair;
    wire [2*DRV_W-1:0]      bias_pair;
    wire [2*DRV_W-1:0]      trim_pair;
    wire [8*`SENSE_COUNT-1:0] next_sense;
    wire [`SENSE_COUNT-1:0]   update;
    wire [7:0]              offset;
    wire [3:0]              idx;
    integer                 k;

    function in_bank;
        input [7:0] a;
        begin
            in_bank = (a >= `SENSE_BASE_ADDR) && (a <= `DRIVER_FOUR_CURRENT_SENSE_ADDR);
        end
    endfunction

    assign offset            = addr - `SENSE_BASE_ADDR;
    assign idx               = offset[3:0];
    assign extra_bias_enable = bias_enable;

    sign_magnitude_split #(
        .IN_W  (LOOP_W),
        .MAG_W (`LOOP_MAGNITUDE_W)
    ) u_loop_volt (
        .sample    (loop_volt_sample),
        .polarity  (volt_polarity),   // R1
        .magnitude (volt_magnitude)   // R2
    );

    sign_magnitude_split #(
        .IN_W  (LOOP_W),
        .MAG_W (`LOOP_MAGNITUDE_W)
    ) u_loop_current (
        .sample    (loop_current_sample),
        .polarity  (cur_polarity),    // R3
        .magnitude (cur_magnitude)    // R4
    );

    assign raw_pair  = {driver_two_current, driver_one_current};
    assign bias_pair = {extra_bias_current_two, extra_bias_current_one};

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_trim
            bias_trim #(
                .W (DRV_W)
            ) u_trim (
                .current_code (raw_pair[g*DRV_W +: DRV_W]),
                .bias_code    (bias_pair[g*DRV_W +: DRV_W]),
                .enable       (bias_enable),                  // R9
                .trimmed      (trim_pair[g*DRV_W +: DRV_W])
            );
        end
    endgenerate

    // next contents, low index in low byte; loop bit 7 forced to zero
    assign next_sense = {
        driver_four_current,                                  // R10
        driver_three_current,                                 // R10
        trim_pair[2*DRV_W-1:DRV_W],                           // R8
        trim_pair[DRV_W-1:0],                                 // R8
        battery_voltage_code_b,                               // R7
        battery_voltage_code_a,                               // R7
        ring_voltage_code,                                    // R6
        tip_voltage_code,                                     // R5
        {1'b0, cur_polarity, cur_magnitude},                  // R11
        {1'b0, volt_polarity, volt_magnitude}                 // R11
    };

    assign update = {{4{driver_valid}}, {4{line_valid}}, {2{loop_valid}}};

    // a fresh sample wins over a read clear in the same cycle
    always @(posedge ref_clk) begin
        for (k = 0; k < `SENSE_COUNT; k = k + 1) begin
            if (srst) begin
                sense[k] <= `SENSE_RESET_VALUE;
            end else if (update[k]) begin
                sense[k] <= next_sense[8*k +: 8];             // R12
            end else if (rd_strobe && in_bank(addr) && (idx == k) && CLEAR_MASK[k]) begin
                sense[k] <= `SENSE_RESET_VALUE;
            end
        end
    end

    // only the extra bias control accepts writes
    always @(posedge ref_clk) begin
        if (srst) begin
            bias_enable <= `EXTRA_BIAS_CTRL_RESET;
        end else if (wr_strobe && addr == `EXTRA_BIAS_CTRL_ADDR) begin
            bias_enable <= wr_data[`EXTRA_BIAS_ENABLE_BIT];
        end
    end

    // writes to sense addresses fall through with no effect
    always @(posedge ref_clk) begin
        if (srst) begin
            rd_data <= 8'h00;
        end else if (!rd_strobe) begin
            rd_data <= 8'h00;
        end else if (in_bank(addr)) begin
            rd_data <= sense[idx];                            // R11
        end else if (addr == `EXTRA_BIAS_CTRL_ADDR) begin
            rd_data <= {7'h00, bias_enable};
        end else begin
            rd_data <= 8'h00;
        end
    end
endmodule

// File: dv/line_sense_props.sv
// port assertions for the line sense register bank
`timescale 1ns/1ps
module line_sense_props #(
    parameter LOOP_W = 9,
    parameter DRV_W  = 8
) (
    input wire              ref_clk,              // clock
    input wire              srst,                 // sync reset
    input wire [7:0]        addr,                 // address
    input wire [7:0]        wr_data,              // write data
    input wire              wr_strobe,            // write
    input wire              rd_strobe,            // read
    input wire [7:0]        rd_data,              // read data
    input wire              loop_valid,           // loop samples
    input wire [LOOP_W-1:0] loop_volt_sample,     // loop voltage
    input wire [LOOP_W-1:0] loop_current_sample,  // loop current
    input wire              line_valid,           // line codes
    input wire [7:0]        tip_voltage_code,     // tip code
    input wire              driver_valid,         // driver codes
    input wire [DRV_W-1:0]  driver_three_current, // driver three
    input wire              extra_bias_enable     // bias control
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    rd_idle_a: assert property (!rd_strobe |=> rd_data == 8'h00)
        else $error("read data not idle");
    ebe_write_a: assert property (wr_strobe && addr == 8'h58 |=>
        extra_bias_enable == $past(wr_data[0])) else $error("bias enable not written");
    ebe_hold_a: assert property (!(wr_strobe && addr == 8'h58) |=>
        $stable(extra_bias_enable)) else $error("bias enable changed");
    unmapped_zero_a: assert property (rd_strobe && (addr < 8'h4E || addr > 8'h58) |=>
        rd_data == 8'h00) else $error("unmapped read not zero");
    loop_bit7_a: assert property (rd_strobe && addr[7:1] == 7'h27 |=> !rd_data[7])
        else $error("loop bit 7 set");
    volt_sign_a: assert property (loop_valid ##1 !loop_valid ##1
        (rd_strobe && addr == 8'h4E) |=> rd_data[6] == $past(loop_volt_sample[LOOP_W-1], 3))
        else $error("voltage sign");
    current_sign_a: assert property (loop_valid ##1 !loop_valid ##1
        (rd_strobe && addr == 8'h4E && !loop_valid) ##1 !loop_valid ##1
        (rd_strobe && addr == 8'h4F) |=> rd_data[6] == $past(loop_current_sample[LOOP_W-1], 5))
        else $error("current sign");
    tip_follow_a: assert property (line_valid ##1 !line_valid ##1
        (rd_strobe && addr == 8'h50) |=> rd_data == $past(tip_voltage_code, 3))
        else $error("tip code");
    drv_three_a: assert property (driver_valid ##1 !driver_valid ##1
        (rd_strobe && addr == 8'h56) |=> rd_data == $past(driver_three_current, 3))
        else $error("driver three code");
    ring_clear_a: assert property ((rd_strobe && addr == 8'h51 && !line_valid) ##1
        !line_valid ##1 (rd_strobe && addr == 8'h51) |=> rd_data == 8'h00)
        else $error("ring not cleared by read");
endmodule

// File: dv/line_sense_readout_bank_test.sv
// self-checking bench for the line sense register bank
`timescale 1ns/1ps
module line_sense_readout_bank_test;
    reg        ref_clk = 1'b0, srst = 1'b1, wr_strobe = 1'b0, rd_strobe = 1'b0;
    reg        loop_valid = 1'b0, line_valid = 1'b0, driver_valid = 1'b0;
    reg  [7:0] addr = 8'h00, wr_data = 8'h00, tip = 8'h00, ring = 8'h00, ba = 8'h00;
    reg  [7:0] bb = 8'h00, d1 = 8'h00, d2 = 8'h00, d3 = 8'h00, d4 = 8'h00;
    reg  [7:0] b1 = 8'h00, b2 = 8'h00;
    reg  [8:0] vs = 9'h000, cs = 9'h000;
    wire [7:0] rd_data;
    wire       extra_bias_enable;
    integer    num_errors = 0, check_count = 0, cycles = 0, i;
    line_sense_readout_bank dut (.ref_clk(ref_clk), .srst(srst), .addr(addr),
        .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
        .loop_valid(loop_valid), .loop_volt_sample(vs), .loop_current_sample(cs),
        .line_valid(line_valid), .tip_voltage_code(tip), .ring_voltage_code(ring),
        .battery_voltage_code_a(ba), .battery_voltage_code_b(bb), .driver_valid(driver_valid),
        .driver_one_current(d1), .driver_two_current(d2), .driver_three_current(d3),
        .driver_four_current(d4), .extra_bias_current_one(b1), .extra_bias_current_two(b2),
        .extra_bias_enable(extra_bias_enable));
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    task check(input [7:0] a, input [7:0] seen, input [7:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("wrong value reg %h expected %h seen %h", a, exp, seen);
        end
    endtask
    task rd(input [7:0] a, input [7:0] exp);
        @(posedge ref_clk);
        rd_strobe <= 1'b1;
        addr      <= a;
        @(posedge ref_clk);
        rd_strobe <= 1'b0;
        #1 check(a, rd_data, exp);
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(posedge ref_clk);
        wr_strobe <= 1'b1;
        addr      <= a;
        wr_data   <= d;
        @(posedge ref_clk);
        wr_strobe <= 1'b0;
    endtask
    // one valid pulse with the data of the selected groups
    task feed(input [2:0] v, input [47:0] x);
        @(posedge ref_clk);
        if (v[2]) {vs, cs} <= x[17:0];
        if (v[1]) {tip, ring, ba, bb} <= x[31:0];
        if (v[0]) {d1, d2, d3, d4, b1, b2} <= x;
        {loop_valid, line_valid, driver_valid} <= v;
        @(posedge ref_clk);
        {loop_valid, line_valid, driver_valid} <= 3'b000;
    endtask
    task lp(input [8:0] v, input [8:0] c, input [7:0] ev, input [7:0] ec);
        feed(3'b100, {30'h0, v, c});
        rd(8'h4E, ev);
        rd(8'h4F, ec);
    endtask
    task test_done;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (cycles == 2000) begin
            num_errors = num_errors + 1;
            test_done;
        end
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        for (i = 'h4D; i <= 'h59; i = i + 1)
            rd(i[7:0], 8'h00);
        lp(9'h1FD, 9'h005, 8'h43, 8'h05);
        lp(9'h03F, 9'h1C1, 8'h3F, 8'h7F);
        lp(9'h040, 9'h100, 8'h3F, 8'h7F);
        lp(9'h000, 9'h1FF, 8'h00, 8'h41);
        feed(3'b010, 48'hA55AC33C);
        rd(8'h50, 8'hA5);
        rd(8'h51, 8'h5A);
        rd(8'h51, 8'h00);
        rd(8'h52, 8'hC3);
        rd(8'h53, 8'h3C);
        wr(8'h50, 8'hFF);
        wr(8'h20, 8'hFF);
        rd(8'h50, 8'hA5);
        rd(8'h20, 8'h00);
        feed(3'b001, 48'h8040FF011050);
        rd(8'h56, 8'hFF);
        rd(8'h54, 8'h80);
        rd(8'h55, 8'h40);
        rd(8'h57, 8'h01);
        rd(8'h57, 8'h00);
        wr(8'h58, 8'h01);
        rd(8'h58, 8'h01);
        check(8'h58, {7'h00, extra_bias_enable}, 8'h01);
        feed(3'b001, 48'h8040FF011050);
        rd(8'h54, 8'h70);
        rd(8'h55, 8'h00);
        rd(8'h54, 8'h00);
        wr(8'h58, 8'h00);
        feed(3'b001, 48'h8040FF011050);
        rd(8'h54, 8'h80);
        // reset in mid-run must clear the control bit and the sense contents
        wr(8'h58, 8'h01);
        @(posedge ref_clk);
        srst <= 1'b1;
        @(posedge ref_clk);
        srst <= 1'b0;
        #1 check(8'h58, {7'h00, extra_bias_enable}, 8'h00);
        rd(8'h50, 8'h00);
        rd(8'h58, 8'h00);
        test_done;
    end
endmodule
bind line_sense_readout_bank line_sense_props #(.LOOP_W(LOOP_W), .DRV_W(DRV_W)) chk (
    .ref_clk(ref_clk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rd_data(rd_data), .loop_valid(loop_valid),
    .loop_volt_sample(loop_volt_sample), .loop_current_sample(loop_current_sample),
    .line_valid(line_valid), .tip_voltage_code(tip_voltage_code), .driver_valid(driver_valid),
    .driver_three_current(driver_three_current), .extra_bias_enable(extra_bias_enable));
